// ### msle_led_view.sv
`timescale 1ns/100ps
`default_nettype none
// counts colour changes as an observer would see them
module msle_led_view
   import msle_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire msle_led_s led,
   output logic [7:0] red_flips,
   output logic [7:0] green_flips
);
   msle_led_s last_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         red_flips <= 8'h0;
         green_flips <= 8'h0;
         last_q <= 2'b00;
      end
      else
      begin
         red_flips <= red_flips + 8'(led.red != last_q.red);
         green_flips <= green_flips + 8'(led.green != last_q.green);
         last_q <= led;
      end
   end
endmodule : msle_led_view
`default_nettype wire

// ### msle_pkg.sv
package msle_pkg;

   // ------------------------------------------------------------------
   // register map, byte addresses, one aligned word each
   // ------------------------------------------------------------------
   localparam logic [7:0] MSLE_OFF_CTRL = 8'h00;
   localparam logic [7:0] MSLE_OFF_OUT_CMD = 8'h04;
   localparam logic [7:0] MSLE_OFF_FAULT_STS = 8'h08;
   localparam logic [7:0] MSLE_OFF_STATUS = 8'h0c;
   localparam logic [7:0] MSLE_OFF_DIR = 8'h10;

   // ------------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------------
   localparam int MSLE_CTRL_W = 7;
   localparam int MSLE_CTRL_ANALOG = 0;
   localparam int MSLE_CTRL_RUN = 1;
   localparam int MSLE_CTRL_STOP = 2;
   localparam int MSLE_CTRL_CFG_BAD = 3;
   localparam int MSLE_CTRL_REPAIR = 4;
   localparam int MSLE_CTRL_CRIT_LOCAL = 5;
   localparam int MSLE_CTRL_CRIT_REMOTE = 6;

   // ------------------------------------------------------------------
   // status field positions
   // ------------------------------------------------------------------
   localparam int MSLE_STS_MODE = 0;
   localparam int MSLE_STS_RED = 3;
   localparam int MSLE_STS_GREEN = 4;
   localparam int MSLE_STS_PH1 = 5;
   localparam int MSLE_STS_PH2 = 6;
   localparam int MSLE_STS_APP_STOP = 7;
   localparam int MSLE_STS_FORCE_OFF = 8;
   localparam int MSLE_STS_SUP_OP = 9;
   localparam int MSLE_STS_SUP_NOM = 10;
   localparam int MSLE_STS_IN_LVL = 16;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [MSLE_CTRL_W-1:0] MSLE_CTRL_RST = 7'h04;
   localparam logic [7:0] MSLE_OUT_CMD_RST = 8'h00;
   localparam logic [3:0] MSLE_DIR_RST = 4'h0;

   // ------------------------------------------------------------------
   // blink timing
   // ------------------------------------------------------------------
   localparam int MSLE_CLK_HZ = 100_000_000;
   localparam int MSLE_BLINK_2HZ_HALF_MS = 250;
   localparam int MSLE_CNT_W = 25;
   localparam logic [MSLE_CNT_W-1:0] MSLE_HALF_CYCLES =
      MSLE_CNT_W'((MSLE_CLK_HZ / 1000) * MSLE_BLINK_2HZ_HALF_MS);

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MSLE_MODE_OFF = 3'h0,
      MSLE_MODE_STOP = 3'h1,
      MSLE_MODE_RUN = 3'h3,
      MSLE_MODE_REPAIR = 3'h2,
      MSLE_MODE_CFG_BAD = 3'h6,
      MSLE_MODE_CRIT_REMOTE = 3'h7,
      MSLE_MODE_CRIT_LOCAL = 3'h5
   } msle_mode_e;

   typedef struct packed {
      logic red;
      logic green;
   } msle_led_s;

   typedef struct packed {
      logic out_of_operating;
      logic out_of_nominal;
   } msle_supply_s;

   typedef struct packed {
      logic [MSLE_CNT_W-1:0] cnt;
      logic ph2;
      logic ph1;
      logic [MSLE_CTRL_W-1:0] ctrl;
      logic [7:0] cmd;
      logic [3:0] dir;
      logic [7:0] fsts;
      msle_mode_e mode;
      msle_led_s ms;
      logic [7:0] in_led;
      logic [7:0] out_led;
      logic [7:0] drive;
      logic app_stop;
      logic [31:0] rdata;
      logic slverr;
   } msle_regs_s;

endpackage : msle_pkg

// ### msle_top.sv
`timescale 1ns/100ps
`default_nettype none

module msle_top
   import msle_pkg::*;
#(
   parameter logic [MSLE_CNT_W-1:0] HALF_CYCLES = MSLE_HALF_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire msle_supply_s supply,
   input wire logic [3:0] input_channels_low,
   input wire logic [3:0] bidirectional_channels_in,
   output logic [3:0] bidirectional_channels_out,
   output logic [3:0] bidirectional_channels_oe,
   output logic [3:0] output_channels,
   input wire logic [7:0] output_fault,
   output msle_led_s module_state_indicator,
   output logic [7:0] input_led,
   output logic [7:0] output_led,
   output logic app_stop
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction : hit

   function automatic msle_led_s led(input logic red, input logic green);
      msle_led_s l;
      l.red = red;
      l.green = green;
      led = l;
   endfunction : led

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   msle_regs_s r_q;
   msle_regs_s r_d;

   logic setup;
   logic wr;
   logic mapped;
   logic crit_any;
   logic force_off;
   logic wrap;
   logic [7:0] in_lvl;
   logic [7:0] on_mask;

   assign setup = ce & psel & ~penable;
   assign wr = ce & psel & penable & pwrite;
   assign mapped = hit(paddr, MSLE_OFF_CTRL) | hit(paddr, MSLE_OFF_OUT_CMD)
                 | hit(paddr, MSLE_OFF_FAULT_STS) | hit(paddr, MSLE_OFF_STATUS)
                 | hit(paddr, MSLE_OFF_DIR);
   assign crit_any = r_q.ctrl[MSLE_CTRL_CRIT_LOCAL] | r_q.ctrl[MSLE_CTRL_CRIT_REMOTE];
   // only the analog variant cuts its outputs on a critical error
   assign force_off = r_q.ctrl[MSLE_CTRL_ANALOG] & crit_any;
   assign wrap = (r_q.cnt >= HALF_CYCLES - MSLE_CNT_W'(1));
   assign in_lvl = {bidirectional_channels_in, input_channels_low};
   // bidirectional channels count as outputs only while driven
   assign on_mask = {r_q.dir, 4'hf};

   always_comb
   begin
      r_d = r_q;

      // ---------------------------------------------------------------
      // shared blink divider
      // ---------------------------------------------------------------
      // one counter for both rates keeps every blink in phase
      if (wrap)
      begin
         r_d.cnt = '0;
         r_d.ph2 = ~r_q.ph2;
         if (r_q.ph2)
         begin
            r_d.ph1 = ~r_q.ph1;
         end
      end
      else
      begin
         r_d.cnt = r_q.cnt + MSLE_CNT_W'(1);
      end

      // ---------------------------------------------------------------
      // register writes
      // ---------------------------------------------------------------
      if (wr && hit(paddr, MSLE_OFF_CTRL))
      begin
         r_d.ctrl = pwdata[MSLE_CTRL_W-1:0];
      end
      if (wr && hit(paddr, MSLE_OFF_OUT_CMD))
      begin
         r_d.cmd = pwdata[7:0];
      end
      if (wr && hit(paddr, MSLE_OFF_DIR))
      begin
         r_d.dir = pwdata[3:0];
      end
      // write one to clear; a fault in the same cycle survives
      if (wr && hit(paddr, MSLE_OFF_FAULT_STS))
      begin
         r_d.fsts = (r_q.fsts & ~pwdata[7:0]) | output_fault;
      end
      else
      begin
         r_d.fsts = r_q.fsts | output_fault;
      end

      // ---------------------------------------------------------------
      // read data captured in the setup phase
      // ---------------------------------------------------------------
      if (setup)
      begin
         r_d.slverr = ~mapped;
         r_d.rdata = '0;
         if (!pwrite)
         begin
            case (1'b1)
               hit(paddr, MSLE_OFF_CTRL):
                  r_d.rdata[MSLE_CTRL_W-1:0] = r_q.ctrl;
               hit(paddr, MSLE_OFF_OUT_CMD):
                  r_d.rdata[7:0] = r_q.cmd;
               hit(paddr, MSLE_OFF_FAULT_STS):
                  r_d.rdata[7:0] = r_q.fsts;
               hit(paddr, MSLE_OFF_DIR):
                  r_d.rdata[3:0] = r_q.dir;
               hit(paddr, MSLE_OFF_STATUS):
               begin
                  r_d.rdata[MSLE_STS_MODE +: 3] = r_q.mode;
                  r_d.rdata[MSLE_STS_RED] = r_q.ms.red;
                  r_d.rdata[MSLE_STS_GREEN] = r_q.ms.green;
                  r_d.rdata[MSLE_STS_PH1] = r_q.ph1;
                  r_d.rdata[MSLE_STS_PH2] = r_q.ph2;
                  r_d.rdata[MSLE_STS_APP_STOP] = r_q.app_stop;
                  r_d.rdata[MSLE_STS_FORCE_OFF] = force_off;
                  r_d.rdata[MSLE_STS_SUP_OP] = supply.out_of_operating;
                  r_d.rdata[MSLE_STS_SUP_NOM] = supply.out_of_nominal;
                  r_d.rdata[MSLE_STS_IN_LVL +: 8] = in_lvl;
               end
               default:
                  r_d.rdata = '0;
            endcase
         end
      end

      // ---------------------------------------------------------------
      // display mode, highest priority first
      // ---------------------------------------------------------------
      if (supply.out_of_operating)
      begin
         r_d.mode = MSLE_MODE_OFF;
      end
      else if (r_q.ctrl[MSLE_CTRL_CRIT_LOCAL])
      begin
         r_d.mode = MSLE_MODE_CRIT_LOCAL;
      end
      else if (r_q.ctrl[MSLE_CTRL_CRIT_REMOTE])
      begin
         r_d.mode = MSLE_MODE_CRIT_REMOTE;
      end
      else if (r_q.ctrl[MSLE_CTRL_CFG_BAD])
      begin
         r_d.mode = MSLE_MODE_CFG_BAD;
      end
      else if (r_q.ctrl[MSLE_CTRL_REPAIR])
      begin
         r_d.mode = MSLE_MODE_REPAIR;
      end
      else if (r_q.ctrl[MSLE_CTRL_STOP] || supply.out_of_nominal)
      begin
         r_d.mode = MSLE_MODE_STOP;
      end
      else if (r_q.ctrl[MSLE_CTRL_RUN])
      begin
         r_d.mode = MSLE_MODE_RUN;
      end
      else
      begin
         r_d.mode = MSLE_MODE_OFF;
      end

      // ---------------------------------------------------------------
      // module-state indicator, from the next mode and phase
      // ---------------------------------------------------------------
      case (r_d.mode)
         MSLE_MODE_OFF:
            r_d.ms = led(1'b0, 1'b0);
         MSLE_MODE_STOP:
            r_d.ms = led(1'b0, r_d.ph1);
         MSLE_MODE_RUN:
            r_d.ms = led(1'b0, 1'b1);
         MSLE_MODE_REPAIR:
         begin
            if (r_q.ctrl[MSLE_CTRL_ANALOG])
            begin
               r_d.ms = led(r_d.ph1, ~r_d.ph1);
            end
            else
            begin
               r_d.ms = led(r_d.ph1, 1'b0);
            end
         end
         MSLE_MODE_CFG_BAD:
            r_d.ms = led(r_d.ph1, 1'b0);
         MSLE_MODE_CRIT_LOCAL:
            r_d.ms = led(r_d.ph2, 1'b0);
         MSLE_MODE_CRIT_REMOTE:
            r_d.ms = led(1'b1, 1'b0);
         default:
            r_d.ms = led(1'b0, 1'b0);
      endcase

      // ---------------------------------------------------------------
      // application stop and output drive
      // ---------------------------------------------------------------
      r_d.app_stop = r_d.ctrl[MSLE_CTRL_CRIT_LOCAL]
                   | r_d.ctrl[MSLE_CTRL_CRIT_REMOTE];
      if (r_d.ctrl[MSLE_CTRL_ANALOG]
          && (r_d.ctrl[MSLE_CTRL_CRIT_LOCAL] || r_d.ctrl[MSLE_CTRL_CRIT_REMOTE]))
      begin
         r_d.drive = 8'h00;
      end
      else
      begin
         r_d.drive = r_d.cmd & {r_d.dir, 4'hf};
      end

      // ---------------------------------------------------------------
      // channel indicators
      // ---------------------------------------------------------------
      r_d.in_led = in_lvl;
      for (int i = 0; i < 8; i++)
      begin
         if (output_fault[i] && on_mask[i])
         begin
            // same phase that drives the red 1 Hz blink
            r_d.out_led[i] = r_d.ph1;
         end
         else
         begin
            r_d.out_led[i] = r_d.drive[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_q <= '{cnt: '0, ph2: 1'b0, ph1: 1'b0, ctrl: MSLE_CTRL_RST,
                  cmd: MSLE_OUT_CMD_RST, dir: MSLE_DIR_RST, fsts: 8'h00,
                  mode: MSLE_MODE_OFF, ms: '0, in_led: 8'h00, out_led: 8'h00,
                  drive: 8'h00, app_stop: 1'b0, rdata: 32'h0000_0000,
                  slverr: 1'b0};
      end
      else if (ce)
      begin
         r_q <= r_d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // a frozen block holds the access phase instead of losing it
   assign pready = ce;
   assign prdata = r_q.rdata;
   assign pslverr = r_q.slverr;
   assign module_state_indicator = r_q.ms;
   assign input_led = r_q.in_led;
   assign output_led = r_q.out_led;
   assign output_channels = r_q.drive[3:0];
   assign bidirectional_channels_out = r_q.drive[7:4];
   assign bidirectional_channels_oe = r_q.dir;
   assign app_stop = r_q.app_stop;

endmodule : msle_top

`default_nettype wire

// ### msle_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module msle_top_checker
   import msle_pkg::*;
#(
   parameter logic [MSLE_CNT_W-1:0] HALF_CYCLES = MSLE_HALF_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire msle_supply_s supply,
   input wire logic [3:0] input_channels_low,
   input wire logic [3:0] bidirectional_channels_in,
   input wire logic [3:0] output_channels,
   input wire logic [7:0] output_fault,
   input wire msle_led_s module_state_indicator,
   input wire logic [7:0] input_led,
   input wire logic [7:0] output_led,
   input wire logic app_stop
);
   // ------
   // shadow of control word and indication class
   // ------
   logic [6:0] ctl_q;
   logic [2:0] cls;
   logic [2:0] cls_q;
   logic [5:0] stab_q;
   logic [26:0] run_q;
   logic red_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_comb
   begin
      if (supply.out_of_operating) cls = 3'h0;
      else if (ctl_q[5]) cls = 3'h3;
      else if (ctl_q[6]) cls = 3'h1;
      else if (ctl_q[3]) cls = 3'h5;
      else if (ctl_q[4]) cls = ctl_q[0] ? 3'h7 : 3'h4;
      else if (ctl_q[2] || supply.out_of_nominal) cls = 3'h6;
      else if (ctl_q[1]) cls = 3'h2;
      else cls = 3'h5;
   end
   // stab_q restarts on any class change so blink runs are judged whole
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_q <= 7'h04;
         cls_q <= 3'h5;
         stab_q <= 6'h0;
         run_q <= 27'h0;
         red_q <= 1'b0;
      end
      else
      begin
         if (psel && penable && pwrite && ce && paddr == MSLE_OFF_CTRL)
            ctl_q <= pwdata[6:0];
         cls_q <= cls;
         stab_q <= (cls != cls_q || !ce) ? 6'h0 : stab_q + 6'(stab_q != 6'h3f);
         red_q <= module_state_indicator.red;
         run_q <= (module_state_indicator.red != red_q) ? 27'h1 : run_q + 27'h1;
      end
   end
   // the indicator lags its class by one cycle, so judge against cls_q
   a_supply_dark: assert property (
      $past(supply.out_of_operating) && $past(ce) |-> module_state_indicator == 2'b00)
      else $error("indicator lit with supply out of range");
   a_remote_red: assert property (
      stab_q >= 6'h3 && cls_q == 3'h1 |-> module_state_indicator == 2'b10)
      else $error("remote error not steady red");
   a_run_green: assert property (
      stab_q >= 6'h3 && cls_q == 3'h2 |-> module_state_indicator == 2'b01)
      else $error("run not steady green");
   a_local_fast: assert property (
      stab_q == 6'h3f && cls_q == 3'h3 && module_state_indicator.red != red_q
      |-> run_q == {2'b0, HALF_CYCLES})
      else $error("local error blink half period wrong");
   a_repair_slow: assert property (
      stab_q == 6'h3f && cls_q == 3'h4 && module_state_indicator.red != red_q
      |-> run_q == {1'b0, HALF_CYCLES, 1'b0})
      else $error("repairable blink half period wrong");
   a_analog_alt: assert property (
      stab_q >= 6'h3 && cls_q == 3'h7
      |-> module_state_indicator.red != module_state_indicator.green)
      else $error("analog repairable not alternating");
   a_outs_off: assert property (
      stab_q >= 6'h3 && ctl_q[0] && ctl_q[6:5] != 2'b00 |-> output_channels == 4'h0)
      else $error("analog outputs on during critical error");
   a_crit_stop: assert property (
      stab_q >= 6'h3 && ctl_q[6:5] != 2'b00 |-> app_stop)
      else $error("application not stopped");
   a_input_led: assert property (
      $past(ce) && $past(presetn)
      |-> input_led == $past({bidirectional_channels_in, input_channels_low}))
      else $error("input indicator does not follow terminal");
   a_fault_sync: assert property (
      stab_q >= 6'h3 && cls_q == 3'h4 && $past(output_fault[0]) && output_fault[0]
      |-> output_led[0] == module_state_indicator.red)
      else $error("fault indicator out of phase");
endmodule : msle_top_checker
bind msle_top msle_top_checker #(.HALF_CYCLES(HALF_CYCLES)) msle_top_checker_i (.pclk, .presetn,
   .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .supply, .input_channels_low,
   .bidirectional_channels_in, .output_channels, .output_fault, .module_state_indicator,
   .input_led, .output_led, .app_stop);
`default_nettype wire

// ### msle_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module msle_top_test;
   import msle_pkg::*;
   // short divider keeps blink windows to tens of cycles
   localparam logic [MSLE_CNT_W-1:0] HALF = 25'h8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   msle_supply_s supply = 2'b00;
   logic [3:0] in_lo = 4'h0;
   logic [3:0] bd_ext = 4'h0;
   logic [3:0] bd_out;
   logic [3:0] bd_oe;
   logic [7:0] ofault = 8'h0;
   logic [3:0] outs;
   msle_led_s ms;
   logic [7:0] in_led;
   logic [7:0] out_led;
   logic app_stop;
   logic [7:0] rf;
   logic [7:0] gf;
   int error_cnt = 0;
   int total_checks = 0;
   wire logic [3:0] bd_in = (bd_oe & bd_out) | (~bd_oe & bd_ext);
   always #5 pclk = ~pclk;
   msle_top #(.HALF_CYCLES(HALF)) msle_top_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .supply, .input_channels_low(in_lo),
      .bidirectional_channels_in(bd_in), .bidirectional_channels_out(bd_out),
      .bidirectional_channels_oe(bd_oe), .output_channels(outs), .output_fault(ofault),
      .module_state_indicator(ms), .input_led(in_led), .output_led(out_led), .app_stop);
   msle_led_view msle_led_view_i (.pclk, .presetn, .led(ms), .red_flips(rf), .green_flips(gf));
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask : wr
   task rchk(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
      chk(nm, x, r);
      chk(nm, {31'h0, xe}, {31'h0, e});
   endtask : rchk
   // one 1 Hz half period is 2*HALF cycles, so 64 cycles hold 4 flips
   task blink(input string nm, input logic [7:0] er, input logic [7:0] eg);
      logic [7:0] r0;
      logic [7:0] g0;
      repeat (8) @(posedge pclk);
      #1;
      r0 = rf;
      g0 = gf;
      repeat (64) @(posedge pclk);
      #1;
      chk(nm, {24'h0, er}, {24'h0, 8'(rf - r0)});
      chk(nm, {24'h0, eg}, {24'h0, 8'(gf - g0)});
   endtask : blink
   task close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   initial
   begin
      #100000;
      error_cnt++;
      close_out;
   end
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("ctrl", MSLE_OFF_CTRL, 32'h4, 1'b0);
      rchk("out_cmd", MSLE_OFF_OUT_CMD, 32'h0, 1'b0);
      rchk("dir", MSLE_OFF_DIR, 32'h0, 1'b0);
      rchk("unmapped", 8'h20, 32'h0, 1'b1);
      blink("stop", 8'd0, 8'd4);
      wr(MSLE_OFF_CTRL, 32'h02);
      blink("run", 8'd0, 8'd0);
      chk("run led", 32'h1, {30'h0, ms});
      @(posedge pclk);
      supply <= 2'b01;
      blink("nominal", 8'd0, 8'd4);
      @(posedge pclk);
      supply <= 2'b10;
      blink("dark", 8'd0, 8'd0);
      chk("dark led", 32'h0, {30'h0, ms});
      @(posedge pclk);
      supply <= 2'b00;
      in_lo <= 4'ha;
      wr(MSLE_OFF_DIR, 32'h3);
      wr(MSLE_OFF_OUT_CMD, 32'h3f);
      repeat (3) @(posedge pclk);
      #1;
      chk("outs", 32'hf, {28'h0, outs});
      chk("in_led", 32'h3a, {24'h0, in_led});
      ofault <= 8'h01;
      wr(MSLE_OFF_CTRL, 32'h12);
      blink("repair", 8'd4, 8'd0);
      chk("out_led", {24'h0, 8'h3e | {7'h0, ms.red}}, {24'h0, out_led});
      rchk("fault_sts", MSLE_OFF_FAULT_STS, 32'h1, 1'b0);
      // clear while the fault still stands: the fault must win
      wr(MSLE_OFF_FAULT_STS, 32'h1);
      rchk("fault_sts kept", MSLE_OFF_FAULT_STS, 32'h1, 1'b0);
      wr(MSLE_OFF_CTRL, 32'h13);
      blink("analog repair", 8'd4, 8'd4);
      wr(MSLE_OFF_CTRL, 32'h0a);
      blink("config", 8'd4, 8'd0);
      wr(MSLE_OFF_CTRL, 32'h23);
      blink("local", 8'd8, 8'd0);
      chk("outs off", 32'h0, {28'h0, outs});
      chk("stop flag", 32'h1, {31'h0, app_stop});
      wr(MSLE_OFF_CTRL, 32'h42);
      blink("remote", 8'd0, 8'd0);
      chk("remote led", 32'h2, {30'h0, ms});
      wr(MSLE_OFF_CTRL, 32'h7f);
      blink("all", 8'd8, 8'd0);
      @(posedge pclk);
      ce <= 1'b0;
      @(posedge pclk);
      #1;
      chk("frozen ready", 32'h0, {31'h0, pready});
      ce <= 1'b1;
      close_out;
   end
endmodule : msle_top_test
`default_nettype wire
